// [fpx_params.svh]
// Constants for the floating-point exception flag and mask unit.
// Assumes inclusion by the package and the design module only.
`ifndef FPX_PARAMS_SVH
`define FPX_PARAMS_SVH

// Register addresses on the plain register port
`define FPX_ADDR_STACK_STATUS 4'h0
`define FPX_ADDR_STACK_CONTROL 4'h1
`define FPX_ADDR_SIMD_CSR 4'h2
`define FPX_ADDR_UNIT_STATE 4'h3

// Exception class bit positions within a six-bit group
`define FPX_B_INVALID 0
`define FPX_B_SUBNORMAL 1
`define FPX_B_ZERO_DIVIDE 2
`define FPX_B_OVERFLOW 3
`define FPX_B_UNDERFLOW 4
`define FPX_B_PRECISION 5

// Field positions: stack flags/masks at bits 0..5, SIMD masks at 7..12
`define FPX_FLAG_LSB 0
`define FPX_FLAG_MSB 5
`define FPX_SIMD_MASK_LSB 7
`define FPX_SIMD_MASK_MSB 12

// Unit state word: one-hot sequencing state, then the set of the last operation
`define FPX_STATE_LSB 0
`define FPX_STATE_MSB 2
`define FPX_LAST_SET_BIT 3

// Reset values: all classes masked, no flags
`define FPX_RST_FLAGS 6'h00
`define FPX_RST_MASKS 6'h3f

`endif

// [fpx_pkg.sv]
// Types for the floating-point exception flag and mask unit.
// Assumes fpx_params.svh is reachable by bare name.
`include "fpx_params.svh"
package fpx_pkg;
  typedef logic [5:0] fpx_class_t;
  typedef logic [31:0] fpx_word_t;
  typedef logic [3:0] fpx_addr_t;
  // Operation sequencing states, one-hot
  typedef enum logic [2:0] {
    FPX_IDLE = 3'b001,
    FPX_POST = 3'b010,
    FPX_DONE = 3'b100
  } fpx_state_e;
endpackage : fpx_pkg

// [fpx_unit.sv]
// Floating-point exception detection, sticky flags, masks and response select.
// Assumes the datapath on the same clock presents operand classes and,
// any number of cycles after compute_go, post-rounding result classes; registers on a plain port.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "fpx_params.svh"
module fpx_unit (
  input wire logic clk, // 50 MHz clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic clk_en, // Freezes all state while low; sys_rst still resets
  input wire logic op_start, // One-cycle pulse: operand classes valid
  input wire logic op_simd, // 1: SIMD instruction, 0: stack instruction
  input wire logic op_is_div, // Operation is a division
  input wire logic op_invalid, // Operands invalid for the operation
  input wire logic op_denormal, // An operand is denormal
  input wire logic a_zero, // Dividend is zero
  input wire logic a_finite, // Dividend is finite
  input wire logic b_zero, // Divisor is zero
  input wire logic a_sign, // Sign of first operand
  input wire logic b_sign, // Sign of second operand
  input wire logic res_valid, // One-cycle pulse: rounded result classes valid
  input wire logic res_overflow, // Rounded result exceeds largest finite
  input wire logic res_tiny, // Result nonzero and tiny
  input wire logic res_inexact, // Result not exactly representable
  input wire fpx_pkg::fpx_addr_t reg_addr, // Register address
  input wire fpx_pkg::fpx_word_t reg_wdata, // Register write data
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  output fpx_pkg::fpx_word_t reg_rdata, // Read data, cycle after strobe
  output logic compute_go, // Pulse: pre-checks passed, compute
  output logic op_abort, // Pulse: operands must stay untouched
  output logic handler_req, // Pulse: transfer to exception handler
  output logic result_done, // Pulse: operation finished
  output logic [1:0] default_sel, // 0 none, 1 quiet NaN, 2 infinity
  output logic default_sign // Sign of the default result
);
  import fpx_pkg::*;

  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_QNAN = 2'h1;
  localparam logic [1:0] SEL_INF = 2'h2;

  // Number of exception classes carried per flag or mask group
  localparam int NCLS = $bits(fpx_class_t);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check: the class type must match the register field width,
  // otherwise the per-class loop and the register fields would disagree
  if (NCLS != (`FPX_FLAG_MSB - `FPX_FLAG_LSB + 1)) begin : g_bad_width
    $error("class type width does not match the flag field");
  end
  if (NCLS != (`FPX_SIMD_MASK_MSB - `FPX_SIMD_MASK_LSB + 1)) begin : g_bad_mask
    $error("class type width does not match the SIMD mask field");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing overview
  // An operation enters with op_start while idle. The pre-computation
  // classes are judged in that same cycle against the mask of the set
  // that owns the instruction. Any unmasked class ends the operation at
  // once with op_abort and handler_req, so the datapath never writes.
  // A masked invalid or divide-zero also ends it at once, but with a
  // default result kind on default_sel instead of a handler request.
  // Otherwise compute_go starts the datapath, and the unit waits in the
  // post state for res_valid, judges the post-computation classes, and
  // finishes with result_done. One done cycle follows so that a new
  // op_start cannot meet a stale res_valid from the datapath.
  // Limitation: op_start outside idle is dropped, not queued; the
  // datapath side is trusted to wait for result_done.

  ////////////////////////////////////////////////////////////////////////////
  // Pre-computation classification
  fpx_class_t pre_ev;
  fpx_class_t post_ev;
  fpx_class_t act_mask;
  logic zdiv_cond;

  always_comb begin
    pre_ev = '0;
    // Divide-zero only for finite nonzero dividends; 0/0 is invalid instead
    zdiv_cond = op_is_div && b_zero && a_finite && !a_zero;
    pre_ev[`FPX_B_INVALID] = op_invalid;
    pre_ev[`FPX_B_SUBNORMAL] = op_denormal;
    pre_ev[`FPX_B_ZERO_DIVIDE] = zdiv_cond && !op_invalid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Post-computation classification uses the mask of the owning set
  always_comb begin
    post_ev = '0;
    post_ev[`FPX_B_OVERFLOW] = res_overflow;
    // Masked underflow needs tiny and inexact; unmasked needs tiny only
    post_ev[`FPX_B_UNDERFLOW] = res_tiny &&
      (res_inexact || !act_mask[`FPX_B_UNDERFLOW]);
    post_ev[`FPX_B_PRECISION] = res_inexact;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag and mask state
  fpx_class_t st_flag_q, st_flag_d;
  fpx_class_t st_mask_q, st_mask_d;
  fpx_class_t sd_flag_q, sd_flag_d;
  // Flag values after any software write, before detections OR in
  fpx_class_t st_flag_wr;
  fpx_class_t sd_flag_wr;
  fpx_class_t sd_mask_q, sd_mask_d;
  logic sd_hi_q, sd_hi_d; // Spare read/write bit 6 of the SIMD word
  logic simd_op_q, simd_op_d;
  fpx_state_e state_q, state_d;
  fpx_word_t rdata_q, rdata_d;
  logic go_q, go_d;
  logic abort_q, abort_d;
  logic hreq_q, hreq_d;
  logic done_q, done_d;
  logic [1:0] sel_q, sel_d;
  logic sign_q, sign_d;
  fpx_class_t ev;
  fpx_class_t trap;
  logic owner_simd;

  // The set used for masking follows the operation in flight
  assign owner_simd = (state_q == FPX_IDLE) ? op_simd : simd_op_q;
  assign act_mask = owner_simd ? sd_mask_q : st_mask_q;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for sequencing, flags and responses
  always_comb begin
    st_flag_wr = st_flag_q;
    st_mask_d = st_mask_q;
    sd_flag_wr = sd_flag_q;
    sd_mask_d = sd_mask_q;
    sd_hi_d = sd_hi_q;
    simd_op_d = simd_op_q;
    state_d = state_q;
    go_d = 1'b0;
    abort_d = 1'b0;
    hreq_d = 1'b0;
    done_d = 1'b0;
    sel_d = sel_q;
    sign_d = sign_q;
    ev = '0;
    trap = '0;
    rdata_d = '0;

    // Software writes first, so a same-cycle detection still sets the flag
    if (reg_wr) begin
      case (reg_addr)
        `FPX_ADDR_STACK_STATUS: st_flag_wr =
          reg_wdata[`FPX_FLAG_MSB:`FPX_FLAG_LSB];
        `FPX_ADDR_STACK_CONTROL: st_mask_d =
          reg_wdata[`FPX_FLAG_MSB:`FPX_FLAG_LSB];
        `FPX_ADDR_SIMD_CSR: begin
          sd_flag_wr = reg_wdata[`FPX_FLAG_MSB:`FPX_FLAG_LSB];
          sd_hi_d = reg_wdata[`FPX_SIMD_MASK_LSB-1];
          sd_mask_d = reg_wdata[`FPX_SIMD_MASK_MSB:`FPX_SIMD_MASK_LSB];
        end
        default: ;
      endcase
    end

    case (state_q)
      FPX_IDLE: begin
        if (op_start) begin
          simd_op_d = op_simd;
          ev = pre_ev;
          trap = ev & ~act_mask;
          sel_d = SEL_NONE;
          sign_d = 1'b0;
          if (|trap) begin
            // Unmasked pre-check: stop before compute, operands stay intact
            abort_d = 1'b1;
            hreq_d = 1'b1;
            done_d = 1'b1;
          end else if (ev[`FPX_B_INVALID]) begin
            sel_d = SEL_QNAN;
            done_d = 1'b1;
          end else if (ev[`FPX_B_ZERO_DIVIDE]) begin
            sel_d = SEL_INF;
            sign_d = a_sign ^ b_sign;
            done_d = 1'b1;
          end else begin
            // Masked denormal keeps going with the denormal value
            go_d = 1'b1;
            state_d = FPX_POST;
          end
        end
      end
      FPX_POST: begin
        if (res_valid) begin
          ev = post_ev;
          trap = ev & ~act_mask;
          hreq_d = |trap;
          done_d = 1'b1;
          state_d = FPX_DONE;
        end
      end
      FPX_DONE: state_d = FPX_IDLE;
      default: state_d = FPX_IDLE;
    endcase

    // Detections OR into the flags in the per-class loop below

    // Read data shows the registers as they stand before this cycle
    if (reg_rd) begin
      case (reg_addr)
        `FPX_ADDR_STACK_STATUS: rdata_d[`FPX_FLAG_MSB:`FPX_FLAG_LSB] = st_flag_q;
        `FPX_ADDR_STACK_CONTROL: rdata_d[`FPX_FLAG_MSB:`FPX_FLAG_LSB] = st_mask_q;
        `FPX_ADDR_SIMD_CSR: begin
          rdata_d[`FPX_FLAG_MSB:`FPX_FLAG_LSB] = sd_flag_q;
          rdata_d[`FPX_SIMD_MASK_LSB-1] = sd_hi_q;
          rdata_d[`FPX_SIMD_MASK_MSB:`FPX_SIMD_MASK_LSB] = sd_mask_q;
        end
        `FPX_ADDR_UNIT_STATE: begin
          rdata_d[`FPX_STATE_MSB:`FPX_STATE_LSB] = state_q;
          rdata_d[`FPX_LAST_SET_BIT] = simd_op_q;
        end
        default: rdata_d = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-class flag update: a detection ORs on top of a same-cycle software
  // write, so a clear can never lose an event (set wins over clear).
  // Only the set that owns the operation is touched; the other set keeps
  // its history untouched, which is what lets software mix both kinds.
  for (genvar i = 0; i < NCLS; i++) begin : g_class
    // Stack set takes events of stack instructions only
    assign st_flag_d[i] = st_flag_wr[i] | (ev[i] & ~simd_op_d);
    // SIMD set takes events of SIMD instructions only
    assign sd_flag_d[i] = sd_flag_wr[i] | (ev[i] & simd_op_d);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; clock enable freezes everything including the pulses.
  // Reset is honoured even with the clock enable low, so a stalled
  // pipeline can still be brought back to the all-masked state.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_flag_q <= `FPX_RST_FLAGS;
      st_mask_q <= `FPX_RST_MASKS;
      sd_flag_q <= `FPX_RST_FLAGS;
      sd_mask_q <= `FPX_RST_MASKS;
      sd_hi_q <= 1'b0;
      simd_op_q <= 1'b0;
      state_q <= FPX_IDLE;
      rdata_q <= '0;
      go_q <= 1'b0;
      abort_q <= 1'b0;
      hreq_q <= 1'b0;
      done_q <= 1'b0;
      sel_q <= SEL_NONE;
      sign_q <= 1'b0;
    end else if (clk_en) begin
      st_flag_q <= st_flag_d;
      st_mask_q <= st_mask_d;
      sd_flag_q <= sd_flag_d;
      sd_mask_q <= sd_mask_d;
      sd_hi_q <= sd_hi_d;
      simd_op_q <= simd_op_d;
      state_q <= state_d;
      rdata_q <= rdata_d;
      go_q <= go_d;
      abort_q <= abort_d;
      hreq_q <= hreq_d;
      done_q <= done_d;
      sel_q <= sel_d;
      sign_q <= sign_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign compute_go = go_q;
  assign op_abort = abort_q;
  assign handler_req = hreq_q;
  assign result_done = done_q;
  assign default_sel = sel_q;
  assign default_sign = sign_q;

endmodule : fpx_unit

// [fpx_unit_properties.sv]
// Port-level timing checks for the exception unit.
// Assumes a bind onto fpx_unit, one clock domain, clk_en held high.
`timescale 1ns/1ps
module fpx_unit_properties (
  input wire logic clk, sys_rst, op_start, op_is_div, op_invalid, // Watched inputs
  input wire logic op_denormal, a_zero, a_finite, b_zero, a_sign, b_sign, // Operand classes
  input wire logic res_valid, compute_go, op_abort, handler_req, result_done, // Handshake
  input wire logic [1:0] default_sel, // Default result kind
  input wire logic default_sign // Default result sign
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic zd;
  // Finite nonzero over zero; invalid wins over it
  assign zd = op_is_div && a_finite && !a_zero && b_zero && !op_invalid;
  ////////////////////////////////////////////////////////////
  // Pre-checks end in either compute or an early finish, never both
  a_pre_split: assert property (op_start |=> compute_go != result_done)
    else $error("pre-check outcome wrong");
  a_post_finish: assert property (res_valid |=> result_done && !compute_go)
    else $error("no finish after result");
  a_trap_whole: assert property (op_abort |-> handler_req && result_done)
    else $error("abort without handler");
  a_handler_done: assert property (handler_req |-> result_done)
    else $error("handler without finish");
  a_invalid_early: assert property (op_start && op_invalid |=> result_done && !compute_go
    && (handler_req || default_sel == 2'h1))
    else $error("invalid response wrong");
  a_zdiv_inf: assert property (op_start && zd |=> result_done && (handler_req ? op_abort
    : default_sel == 2'h2 && default_sign == $past(a_sign ^ b_sign)))
    else $error("divide-zero response wrong");
  a_denorm_go: assert property (op_start && op_denormal && !op_invalid && !zd
    |=> compute_go != op_abort)
    else $error("denormal response wrong");
  a_sel_hold: assert property (!op_start |=> $stable(default_sel))
    else $error("default kind moved");
  c_abort: cover property (op_abort);
  c_post_trap: cover property (res_valid ##1 handler_req);
  c_inf: cover property (default_sel == 2'h2);
endmodule : fpx_unit_properties
bind fpx_unit fpx_unit_properties u_props (.*);

// [fpx_dp_model.sv]
// Datapath stand-in: answers compute_go with rounded-result classes.
// Assumes the unit's clock and synchronous reset.
`timescale 1ns/1ps
module fpx_dp_model (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic compute_go, // Start compute
  input wire logic [1:0] lat, // Extra compute cycles
  input wire logic [2:0] cls, // Overflow, tiny, inexact to report
  output logic res_valid, // Result classes valid
  output logic res_overflow, res_tiny, res_inexact // Result classes
);
  logic busy_q;
  logic [1:0] cnt_q;
  // Count down the latency, one result per go
  always_ff @(posedge clk) begin
    if (sys_rst) busy_q <= 1'b0;
    else if (compute_go) begin
      busy_q <= 1'b1;
      cnt_q <= lat;
    end else if (busy_q && cnt_q == 2'h0) busy_q <= 1'b0;
    else cnt_q <= cnt_q - 2'h1;
  end
  assign res_valid = busy_q && cnt_q == 2'h0;
  // Outside the pulse show the inverse, so stale classes cannot pass
  assign {res_overflow, res_tiny, res_inexact} = res_valid ? cls : ~cls;
endmodule : fpx_dp_model

// [tb_top.sv]
// Self-checking bench for the exception unit.
// Assumes the datapath model and the bound checker.
`timescale 1ns/1ps
module tb_top;
  import fpx_pkg::*;
  logic clk = 0, sys_rst = 1, clk_en = 1, op_start = 0, op_simd = 0, op_is_div = 0;
  logic op_invalid = 0, op_denormal = 0, a_zero = 0, a_finite = 0, b_zero = 0;
  logic a_sign = 0, b_sign = 0, reg_wr = 0, reg_rd = 0;
  logic res_valid, res_overflow, res_tiny, res_inexact, compute_go, op_abort;
  logic handler_req, result_done, default_sign;
  logic [1:0] default_sel, lat = 0;
  logic [2:0] cls = 0;
  fpx_addr_t reg_addr = '0;
  fpx_word_t reg_wdata = '0, reg_rdata;
  int bad_count = 0, num_checks = 0;
  fpx_unit u_dut (.*);
  fpx_dp_model u_dp (.*);
  initial forever #10 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  // Bus cycles: strobe held exactly one edge
  task wr(input fpx_addr_t a, input fpx_word_t d);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input fpx_addr_t a, input fpx_word_t e);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata === e, "read data");
  endtask : rd
  // One operation; p = div,inv,den,azero,afin,bzero,asign,bsign
  task op(input logic s, input logic [7:0] p, input logic [2:0] q, input logic eh,
      input logic ea, input logic [1:0] es);
    logic done;
    logic seen_go;
    done = 0;
    seen_go = 0;
    @(posedge clk);
    op_start <= 1'b1;
    op_simd <= s;
    {op_is_div, op_invalid, op_denormal, a_zero, a_finite, b_zero, a_sign, b_sign} <= p;
    cls <= q;
    @(posedge clk);
    op_start <= 1'b0;
    repeat (20) if (!done) begin
      #1;
      if (compute_go === 1'b1) seen_go = 1;
      if (result_done === 1'b1) done = 1;
      else @(posedge clk);
    end
    chk(done, "no finish");
    if (!done) finish_test;
    chk(handler_req === eh && default_sel === es, "response");
    if (es == 2'h2) chk(default_sign === (p[1] ^ p[0]), "inf sign");
    chk(op_abort === ea, "abort");
    chk(seen_go === !(ea || es != 2'h0), "compute start");
    repeat (2) @(posedge clk);
  endtask : op
  ////////////////////////////////////////////////////////////
  task s_reset;
    rd(4'h0, 32'h0);
    rd(4'h1, 32'h3f);
    rd(4'h2, 32'h1f80);
    rd(4'h9, 32'h0);
    rd(4'h3, 32'h1);
  endtask : s_reset
  // Masked classes pile up within one op and across ops
  task s_masked;
    op(1'b0, 8'h20, 3'b011, 1'b0, 1'b0, 2'h0);
    rd(4'h0, 32'h32);
    rd(4'h2, 32'h1f80);
    op(1'b0, 8'h40, 3'b000, 1'b0, 1'b0, 2'h1);
    op(1'b0, 8'h8e, 3'b000, 1'b0, 1'b0, 2'h2);
    rd(4'h0, 32'h37);
  endtask : s_masked
  // Unmasked divide-zero on the SIMD set only
  task s_simd;
    wr(4'h2, 32'h1d80);
    op(1'b1, 8'h8e, 3'b000, 1'b1, 1'b1, 2'h0);
    rd(4'h2, 32'h1d84);
    rd(4'h3, 32'h9);
    rd(4'h0, 32'h37);
  endtask : s_simd
  // Unmasked overflow after a slow compute, then a clear
  task s_post;
    wr(4'h1, 32'h37);
    lat <= 2'h3;
    op(1'b0, 8'h00, 3'b101, 1'b1, 1'b0, 2'h0);
    rd(4'h0, 32'h3f);
    wr(4'h0, 32'h0);
    op(1'b0, 8'h00, 3'b010, 1'b0, 1'b0, 2'h0);
    rd(4'h0, 32'h0);
  endtask : s_post
  // A write while the clock enable is low must not land
  task s_freeze;
    @(posedge clk);
    clk_en <= 1'b0;
    wr(4'h0, 32'h3f);
    clk_en <= 1'b1;
    rd(4'h0, 32'h0);
  endtask : s_freeze
  // Mid-run reset brings masks back to all set and clears SIMD flags
  task s_rerst;
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    rd(4'h1, 32'h3f);
    rd(4'h2, 32'h1f80);
  endtask : s_rerst
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    s_reset;
    s_masked;
    s_simd;
    s_post;
    s_freeze;
    s_rerst;
    finish_test;
  end
endmodule : tb_top
